/* hw/cbt_pkg.sv */
/*
 * Constants shared by both ends of the CAN timing, interrupt and filter
 * configuration block: register indices, field positions, masks, reset
 * values and the controller's own APB map.
 * Assumes a single 125 MHz clock domain for both ends.
 */
package cbt_pkg;
	// Device register indices on the register link
	localparam logic [1:0]  IDX_TIMING = 2'h0;
	localparam logic [1:0]  IDX_INTR   = 2'h1;
	localparam logic [1:0]  IDX_FILTER = 2'h2;
	localparam logic [1:0]  IDX_CTRL   = 2'h3;

	// Bit-timing register fields
	localparam int          PRESC_LSB  = 0;
	localparam int          SJW_LSB    = 6;
	localparam int          PROP_LSB   = 8;
	localparam int          PH1_LSB    = 11;
	localparam int          SAMPLE3_BIT = 14;
	localparam int          PH2PROG_BIT = 15;
	localparam int          PH2_LSB    = 16;
	localparam logic [31:0] TIMING_WMASK = 32'h0007_FFFF;
	localparam logic [5:0]  PRESC_MIN_SAMPLE3 = 6'h02;
	localparam logic [4:0]  QUANTA_MIN_EXCL = 5'h07;

	// Interrupt register layout
	localparam int          EN_HI_LSB  = 27;
	localparam int          EN_LO_LSB  = 16;
	localparam int          FL_HI_LSB  = 11;
	localparam int          FL_LO_LSB  = 0;
	localparam int          SYSERR_FLAG_BIT = 12;
	localparam int          NUM_EVENTS = 9;
	localparam logic [31:0] INTR_EN_MASK = 32'hF80F_0000;
	localparam logic [31:0] INTR_FL_MASK = 32'h0000_F80F;

	// Filter control: filter n occupies byte n
	localparam int          FLT_STRIDE = 8;
	localparam int          FLT_EN_OFS = 7;
	localparam int          FLT_MSEL_OFS = 5;
	localparam int          FLT_FSEL_OFS = 0;
	localparam int          NUM_FILTERS = 2;

	// Control register
	localparam int          ON_BIT     = 15;
	localparam int          OPMODE_LSB = 21;
	localparam logic [2:0]  OPMODE_CONFIG = 3'h4;
	localparam logic [31:0] CTRL_WMASK = 32'h00E0_8000;
	localparam logic [31:0] CTRL_RESET = 32'h0080_0000;

	// Controller APB map (byte addresses)
	localparam logic [7:0]  APB_CMD    = 8'h00;
	localparam logic [7:0]  APB_WDATA  = 8'h04;
	localparam logic [7:0]  APB_RDATA  = 8'h08;
	localparam logic [7:0]  APB_STATUS = 8'h0C;
	localparam logic [7:0]  APB_MASK   = 8'h10;
	localparam int          CMD_GO_BIT = 0;
	localparam int          CMD_WE_BIT = 1;
	localparam int          CMD_IDX_LSB = 4;
	localparam int          ST_DONE    = 0;
	localparam int          ST_REFUSED = 1;
	localparam int          ST_BUSY    = 2;

	typedef enum logic [1:0] {
		CBT_IDLE  = 2'h0,
		CBT_ISSUE = 2'h1
	} cbt_state_e;
endpackage : cbt_pkg

/* hw/cbt_if.sv */
/*
 * Register link between the controller and the configuration device.
 * Assumes both ends run on the same clock; the bench supplies it.
 */
`timescale 1ns/1ps
interface cbt_if;
	logic        req;
	logic        we;
	logic [1:0]  idx;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        ack;
	logic        can_irq;

	modport device (input req, input we, input idx, input wdata,
		output rdata, output ack, output can_irq);
	modport ctrl (output req, output we, output idx, output wdata,
		input rdata, input ack, input can_irq);
endinterface : cbt_if

/* hw/cbt_dev.sv */
/*
 * Configuration device: bit-timing register with quantum tick, interrupt
 * enable/flag register, two acceptance filter controls, control register.
 * Register link: one access per req, answered by a one-cycle ack with
 * read data registered alongside; every access is acked, kept or not.
 * Assumes event inputs come from logic on pclk (no synchroniser) and that
 * the controller holds req until ack.
 * Assumes the controller screens timing and filter words; this end only
 * enforces the mode lock and the filter enable lock by itself.
 */
`timescale 1ns/1ps
module cbt_dev (
	input  wire logic                pclk,
	input  wire logic                presetn,
	cbt_if.device                    link,
	input  wire logic [8:0]          events,
	output logic                     module_on,
	output logic [2:0]               operating_mode_field,
	output logic                     quantum_tick,
	output logic [3:0]               propagation_segment,
	output logic [2:0]               resync_jump_width,
	output logic [3:0]               phase_one_segment,
	output logic [3:0]               phase_two_segment,
	output logic                     three_sample,
	output logic [1:0]               filter_enable,
	output logic [3:0]               filter_mask_choice,
	output logic [9:0]               filter_fifo_choice
);
	import cbt_pkg::*;

	typedef struct packed {
		logic [31:0] timing;
		logic [31:0] intr;
		logic [31:0] filter;
		logic [31:0] ctrl;
		logic [6:0]  tq_cnt;
		logic        tick;
		logic        ack;
		logic [31:0] rdata;
	} cbt_dev_s;

	// Whole device state and its combinational copy
	cbt_dev_s st;
	cbt_dev_s next_st;

	logic        wr;
	logic [31:0] event_bits;
	logic [6:0]  tq_last;
	logic [5:0]  presc;
	logic [2:0]  ph1_raw;
	logic [2:0]  ph2_raw;
	logic        ph2_prog;

	// Field views of the timing register
	// One decode shared by the phase outputs and the divider
	assign presc    = st.timing[PRESC_LSB +: 6];
	assign ph1_raw  = st.timing[PH1_LSB +: 3];
	assign ph2_raw  = st.timing[PH2_LSB +: 3];
	assign ph2_prog = st.timing[PH2PROG_BIT];

	// Last count of one quantum: 2*(presc+1) pclk periods
	// Seven bits cover the longest quantum of 128 periods
	assign tq_last = {presc, 1'b1};

	// Map the nine events onto their flag positions
	// Every high cycle of an event sets its flag again
	assign event_bits = (32'(events[8:4]) << FL_HI_LSB) | (32'(events[3:0]) << FL_LO_LSB);

	// A write acts once, at the edge that raises ack
	assign wr = link.req & link.we & ~st.ack;

	// Next-state logic for every register of the device
	always_comb begin
		// Defaults: hold every register, drop the one-cycle pulses
		next_st = st;
		next_st.tick = 1'b0;
		next_st.ack = link.req & ~st.ack;

		// Control register: module enable and operating mode
		// Only those bits are kept; the rest read zero
		if (wr && link.idx == IDX_CTRL) begin
			next_st.ctrl = link.wdata & CTRL_WMASK;
		end

		// Timing writes are dropped outside configuration mode
		// The access is still acked, so the link never stalls
		if (wr && link.idx == IDX_TIMING &&
			st.ctrl[OPMODE_LSB +: 3] == OPMODE_CONFIG) begin
			next_st.timing = link.wdata & TIMING_WMASK;
		end

		// Enables and flags; system error flag ignores software
		if (wr && link.idx == IDX_INTR) begin
			next_st.intr = (link.wdata & (INTR_EN_MASK | INTR_FL_MASK));
			next_st.intr[SYSERR_FLAG_BIT] = st.intr[SYSERR_FLAG_BIT];
		end
		// Turning the module off clears the system error flag
		// A flag raised while off stays until the next off edge
		if (st.ctrl[ON_BIT] && !next_st.ctrl[ON_BIT]) begin
			next_st.intr[SYSERR_FLAG_BIT] = 1'b0;
		end
		// Hardware set wins over any clear in the same cycle
		next_st.intr = next_st.intr | event_bits;

		// Each filter byte: enable always writable, fields only if disabled
		if (wr && link.idx == IDX_FILTER) begin
			for (int f = 0; f < NUM_FILTERS; f++) begin
				next_st.filter[f*FLT_STRIDE + FLT_EN_OFS] =
					link.wdata[f*FLT_STRIDE + FLT_EN_OFS];
				if (!st.filter[f*FLT_STRIDE + FLT_EN_OFS]) begin
					next_st.filter[f*FLT_STRIDE + FLT_MSEL_OFS +: 2] =
						link.wdata[f*FLT_STRIDE + FLT_MSEL_OFS +: 2];
					next_st.filter[f*FLT_STRIDE + FLT_FSEL_OFS +: 5] =
						link.wdata[f*FLT_STRIDE + FLT_FSEL_OFS +: 5];
				end
			end
		end

		// Quantum divider; held in reset while the module is off
		// Counting to an odd last value gives an even quantum
		if (!st.ctrl[ON_BIT]) begin
			next_st.tq_cnt = 7'h00;
		end else if (st.tq_cnt >= tq_last) begin
			next_st.tq_cnt = 7'h00;
			next_st.tick = 1'b1;
		end else begin
			next_st.tq_cnt = st.tq_cnt + 7'h01;
		end

		// Read data registered alongside ack; unused bits read zero
		// A write access returns the value from before the write
		if (link.req && !st.ack) begin
			case (link.idx)
				IDX_TIMING: next_st.rdata = st.timing;
				IDX_INTR:   next_st.rdata = st.intr;
				IDX_FILTER: next_st.rdata = st.filter;
				IDX_CTRL:   next_st.rdata = st.ctrl;
				default:    next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// One register bank for all state
	// Control starts in configuration mode with the module off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.timing <= 32'h0000_0000;
			st.intr   <= 32'h0000_0000;
			st.filter <= 32'h0000_0000;
			st.ctrl   <= CTRL_RESET;
			st.tq_cnt <= 7'h00;
			st.tick   <= 1'b0;
			st.ack    <= 1'b0;
			st.rdata  <= 32'h0000_0000;
		end else begin
			st <= next_st;
		end
	end

	// Link answers
	// Straight from flip-flops, so no combinational path on the link
	assign link.ack   = st.ack;
	assign link.rdata = st.rdata;

	// Request when any flag meets its enable
	// Combinational, so the request follows a flag in its own cycle
	assign link.can_irq = |((st.intr[EN_HI_LSB +: 5] & st.intr[FL_HI_LSB +: 5]))
		| |((st.intr[EN_LO_LSB +: 4] & st.intr[FL_LO_LSB +: 4]));

	// Timing outputs in quanta
	// Each length is its field value plus one
	assign quantum_tick         = st.tick;
	assign propagation_segment  = {1'b0, st.timing[PROP_LSB +: 3]} + 4'h1;
	assign resync_jump_width    = {1'b0, st.timing[SJW_LSB +: 2]} + 3'h1;
	assign phase_one_segment    = {1'b0, ph1_raw} + 4'h1;
	// Auto phase two equals phase one, so it never exceeds it
	assign phase_two_segment    = {1'b0, (ph2_prog ? ph2_raw : ph1_raw)} + 4'h1;
	assign three_sample         = st.timing[SAMPLE3_BIT];
	assign module_on            = st.ctrl[ON_BIT];
	assign operating_mode_field = st.ctrl[OPMODE_LSB +: 3];

	// Filter outputs, one slice per filter
	// Filter n sits in byte n of the filter control word
	genvar g;
	generate
		for (g = 0; g < NUM_FILTERS; g++) begin : g_flt
			assign filter_enable[g]          = st.filter[g*FLT_STRIDE + FLT_EN_OFS];
			assign filter_mask_choice[g*2 +: 2] = st.filter[g*FLT_STRIDE + FLT_MSEL_OFS +: 2];
			assign filter_fifo_choice[g*5 +: 5] = st.filter[g*FLT_STRIDE + FLT_FSEL_OFS +: 5];
		end
	endgenerate
endmodule : cbt_dev

/* hw/cbt_ctrl.sv */
/*
 * Controller end: APB slave for software, issues single register accesses
 * on the link and refuses timing or filter writes that break the rules.
 * Assumes the device answers every request with a one-cycle ack.
 */
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module cbt_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	cbt_if.ctrl              link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             irq
);
	import cbt_pkg::*;

	typedef struct packed {
		cbt_state_e  fsm;
		logic        we;
		logic [1:0]  idx;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [1:0]  stat;
		logic [1:0]  mask;
		logic [2:0]  opmode;
		logic [1:0]  flt_en;
		logic [31:0] flt_shadow;
		logic [31:0] prdata;
	} cbt_ctrl_s;

	cbt_ctrl_s st;
	cbt_ctrl_s next_st;

	logic        apb_wr;
	logic        apb_rd;
	logic        go;
	logic        bad;
	logic [4:0]  quanta;
	logic [2:0]  ph2_eff;

	assign pready = penable;
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & penable & ~pwrite;
	assign go = apb_wr && paddr == APB_CMD && pwdata[CMD_GO_BIT] && st.fsm == CBT_IDLE;

	// Quanta per bit of a proposed timing word
	assign ph2_eff = st.wdata[PH2PROG_BIT] ? st.wdata[PH2_LSB +: 3] : st.wdata[PH1_LSB +: 3];
	assign quanta = 5'h4 + {2'h0, st.wdata[PROP_LSB +: 3]} + {2'h0, st.wdata[PH1_LSB +: 3]}
		+ {2'h0, ph2_eff};

	// Screen a write against the far-end limits before it is sent
	always_comb begin
		bad = 1'b0;
		if (pwdata[CMD_WE_BIT]) begin
			case (pwdata[CMD_IDX_LSB +: 2])
				IDX_TIMING: begin
					bad = (st.opmode != OPMODE_CONFIG)
						| (st.wdata[SAMPLE3_BIT] & (st.wdata[PRESC_LSB +: 6] < PRESC_MIN_SAMPLE3))
						| (quanta <= QUANTA_MIN_EXCL)
						| (ph2_eff > st.wdata[PH1_LSB +: 3])
						| (st.wdata[SJW_LSB +: 2] > ph2_eff);
				end
				IDX_FILTER: begin
					for (int f = 0; f < NUM_FILTERS; f++) begin
						if (st.flt_en[f] && (st.wdata[f*FLT_STRIDE +: 7]
							!= st.flt_shadow[f*FLT_STRIDE +: 7])) begin
							bad = 1'b1;
						end
					end
				end
				default: bad = 1'b0;
			endcase
		end
	end

	// Register map, command sequencer and sticky status
	always_comb begin
		next_st = st;
		if (apb_wr && paddr == APB_WDATA) begin
			next_st.wdata = pwdata;
		end
		if (apb_wr && paddr == APB_MASK) begin
			next_st.mask = pwdata[1:0];
		end
		// Reading status clears the sticky bits
		if (apb_rd && paddr == APB_STATUS) begin
			next_st.stat = 2'h0;
		end

		case (st.fsm)
			CBT_IDLE: begin
				if (go && bad) begin
					next_st.stat[ST_REFUSED] = 1'b1;
				end else if (go) begin
					next_st.we  = pwdata[CMD_WE_BIT];
					next_st.idx = pwdata[CMD_IDX_LSB +: 2];
					next_st.fsm = CBT_ISSUE;
				end
			end
			CBT_ISSUE: begin
				if (link.ack) begin
					next_st.rdata = link.rdata;
					next_st.stat[ST_DONE] = 1'b1;
					next_st.fsm = CBT_IDLE;
					// Track what the device now holds
					if (st.we && st.idx == IDX_CTRL) begin
						next_st.opmode = st.wdata[OPMODE_LSB +: 3];
					end
					if (st.we && st.idx == IDX_FILTER) begin
						for (int f = 0; f < NUM_FILTERS; f++) begin
							next_st.flt_en[f] = st.wdata[f*FLT_STRIDE + FLT_EN_OFS];
							if (!st.flt_en[f]) begin
								next_st.flt_shadow[f*FLT_STRIDE +: 7] = st.wdata[f*FLT_STRIDE +: 7];
							end
						end
					end
				end
			end
			default: next_st.fsm = CBT_IDLE;
		endcase

		// Read data is fetched in the setup phase
		if (psel && !penable) begin
			case (paddr)
				APB_CMD:    next_st.prdata = 32'(st.idx) << CMD_IDX_LSB
					| 32'(st.we) << CMD_WE_BIT;
				APB_WDATA:  next_st.prdata = st.wdata;
				APB_RDATA:  next_st.prdata = st.rdata;
				APB_STATUS: next_st.prdata = 32'({st.fsm == CBT_ISSUE, next_st.stat});
				APB_MASK:   next_st.prdata = 32'(st.mask);
				default:    next_st.prdata = 32'h0000_0000;
			endcase
		end
	end

	// One register bank for all state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.fsm        <= CBT_IDLE;
			st.we         <= 1'b0;
			st.idx        <= 2'h0;
			st.wdata      <= 32'h0000_0000;
			st.rdata      <= 32'h0000_0000;
			st.stat       <= 2'h0;
			st.mask       <= 2'h0;
			st.opmode     <= OPMODE_CONFIG;
			st.flt_en     <= 2'h0;
			st.flt_shadow <= 32'h0000_0000;
			st.prdata     <= 32'h0000_0000;
		end else begin
			st <= next_st;
		end
	end

	// Link drive and interrupt
	assign link.req   = (st.fsm == CBT_ISSUE);
	assign link.we    = st.we;
	assign link.idx   = st.idx;
	assign link.wdata = st.wdata;
	assign prdata     = st.prdata;
	assign irq        = |(st.stat & st.mask);
endmodule : cbt_ctrl

/* tb/cbt_props.sv */
/* Link checker: handshake on the register link and legality of what
   the controller sends. Assumes one pclk domain, reset presetn. */
`timescale 1ns/1ps
module cbt_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        req,
	input wire logic        we,
	input wire logic [1:0]  idx,
	input wire logic [31:0] wdata,
	input wire logic        ack
);
	import cbt_pkg::*;
	logic [2:0]  mode;
	logic [15:0] flt;
	logic        tw;
	logic [4:0]  quanta;
	// Shadows of what reached the device; refused writes never get here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= OPMODE_CONFIG;
			flt  <= 16'h0000;
		end else if (req && ack && we && idx == IDX_CTRL)
			mode <= wdata[OPMODE_LSB +: 3];
		else if (req && ack && we && idx == IDX_FILTER)
			flt <= wdata[15:0];
	end
	// Pending timing write, quanta with the phase two the device will use
	assign tw     = req && !ack && we && idx == IDX_TIMING;
	assign quanta = 5'h4 + wdata[10:8] + wdata[13:11]
		+ (wdata[PH2PROG_BIT] ? wdata[18:16] : wdata[13:11]);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_take;
		req && !ack;
	endsequence
	sequence s_answer;
		ack ##1 (!ack && !req);
	endsequence
	ack_in_one_a: assert property (s_take |=> s_answer)
		else $error("link answer late or long");
	req_steady_a: assert property (s_take |=> $stable({we, idx, wdata}))
		else $error("link request changed before ack");
	ack_caused_a: assert property (ack |-> $past(req) && !$past(ack))
		else $error("ack without request");
	timing_mode_a: assert property (tw |-> mode == OPMODE_CONFIG)
		else $error("timing write outside configuration");
	three_sample_a: assert property (tw && wdata[SAMPLE3_BIT] |->
		wdata[5:0] >= PRESC_MIN_SAMPLE3) else $error("three samples, low prescaler");
	quanta_min_a: assert property (tw |-> quanta > QUANTA_MIN_EXCL)
		else $error("too few quanta per bit");
	phase_order_a: assert property (tw && wdata[PH2PROG_BIT] |->
		wdata[18:16] <= wdata[13:11]) else $error("phase two above phase one");
	jump_width_a: assert property (tw && wdata[PH2PROG_BIT] |->
		wdata[7:6] <= wdata[18:16]) else $error("jump width above phase two");
	filter_lock_a: assert property (req && !ack && we && idx == IDX_FILTER |->
		(!flt[7] || wdata[6:0] == flt[6:0]) && (!flt[15] || wdata[14:8] == flt[14:8]))
		else $error("enabled filter fields changed");
endmodule : cbt_props

/* tb/can_timing_irq_filter_cfg_test.sv */
/* Bench: APB side of the controller, event inputs of the device and a
   register model compared after every access. Assumes the hw/ files. */
`timescale 1ns/1ps
module can_timing_irq_filter_cfg_test;
	import cbt_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, v;
	logic [8:0]  events;
	logic        module_on, quantum_tick, three_sample;
	logic [2:0]  operating_mode_field, resync_jump_width;
	logic [3:0]  propagation_segment, phase_one_segment, phase_two_segment;
	logic [1:0]  filter_enable;
	logic [3:0]  filter_mask_choice;
	logic [9:0]  filter_fifo_choice;
	bit [31:0]   m [4];
	int          miscompares, num_checks, seed;

	cbt_if i_cbt_if ();
	cbt_ctrl i_cbt_ctrl (.pclk, .presetn, .link(i_cbt_if.ctrl), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .irq);
	cbt_dev i_cbt_dev (.pclk, .presetn, .link(i_cbt_if.device), .events, .module_on,
		.operating_mode_field, .quantum_tick, .propagation_segment,
		.resync_jump_width, .phase_one_segment, .phase_two_segment, .three_sample,
		.filter_enable, .filter_mask_choice, .filter_fifo_choice);
	cbt_props i_cbt_props (.pclk, .presetn, .req(i_cbt_if.req), .we(i_cbt_if.we),
		.idx(i_cbt_if.idx), .wdata(i_cbt_if.wdata), .ack(i_cbt_if.ack));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd_data);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_data = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Device access through the controller; status read also collects refusal
	task automatic link_op(input logic w, input logic [1:0] i, input logic [31:0] d,
		output logic [31:0] rd_data, output logic refused);
		logic [31:0] st;
		int          n;
		refused = 1'b0;
		n = 0;
		if (w)
			apb(1'b1, APB_WDATA, d, st);
		apb(1'b1, APB_CMD, (32'(i) << CMD_IDX_LSB) | (32'(w) << CMD_WE_BIT) | 32'h1, st);
		do begin
			apb(1'b0, APB_STATUS, 32'h0, st);
			refused = refused | st[ST_REFUSED];
			n++;
		end while (st[ST_BUSY] !== 1'b0 && n < 50);
		if (n == 50) begin
			miscompares++;
			$display("unexpected at %0t: link access never finished", $time);
		end
		apb(1'b0, APB_RDATA, 32'h0, rd_data);
	endtask : link_op

	// Model of a write; returns 0 where the write must be refused
	function automatic bit model(input logic [1:0] i, input logic [31:0] d);
		int q;
		int p2;
		p2 = d[15] ? d[18:16] : d[13:11];
		q = 4 + d[10:8] + d[13:11] + p2;
		case (i)
			IDX_TIMING: begin
				if (m[3][23:21] != OPMODE_CONFIG || (d[14] && d[5:0] < PRESC_MIN_SAMPLE3)
					|| q <= 7 || p2 > d[13:11] || d[7:6] > p2)
					return 1'b0;
				m[0] = d & TIMING_WMASK;
			end
			IDX_INTR: m[1] = (d & (INTR_EN_MASK | INTR_FL_MASK) & ~32'h1000) | (m[1] & 32'h1000);
			IDX_FILTER: begin
				if ((m[2][7] && d[6:0] != m[2][6:0]) || (m[2][15] && d[14:8] != m[2][14:8]))
					return 1'b0;
				m[2] = d & 32'hFFFF;
			end
			default: begin
				if (m[3][15] && !d[15])
					m[1][12] = 1'b0;
				m[3] = d & CTRL_WMASK;
			end
		endcase
		return 1'b1;
	endfunction : model

	task automatic outs;
		check(propagation_segment, m[0][10:8] + 1);
		check(resync_jump_width, m[0][7:6] + 1);
		check(phase_one_segment, m[0][13:11] + 1);
		check(phase_two_segment, (m[0][15] ? m[0][18:16] : m[0][13:11]) + 1);
		check(three_sample, m[0][14]);
		check({module_on, operating_mode_field}, {m[3][15], m[3][23:21]});
		check(filter_enable, {m[2][15], m[2][7]});
		check(filter_mask_choice, {m[2][14:13], m[2][6:5]});
		check(filter_fifo_choice, {m[2][12:8], m[2][4:0]});
		check(i_cbt_if.can_irq, |({m[1][31:27], m[1][19:16]} & {m[1][15:11], m[1][3:0]}));
	endtask : outs

	task automatic rd(input logic [1:0] i);
		logic [31:0] d;
		logic        rf;
		link_op(1'b0, i, 32'h0, d, rf);
		check(d, m[i]);
		outs();
	endtask : rd

	task automatic wr(input logic [1:0] i, input logic [31:0] d);
		logic [31:0] x;
		logic        rf;
		bit          ok;
		ok = model(i, d);
		link_op(1'b1, i, d, x, rf);
		check(rf, !ok);
		rd(i);
	endtask : wr

	// One-cycle event burst; each high cycle sets its flag
	task automatic pulse(input logic [8:0] e);
		@(posedge pclk);
		events <= e;
		@(posedge pclk);
		events <= 9'h000;
		m[1] = m[1] | (32'(e[8:4]) << 11) | 32'(e[3:0]);
	endtask : pulse

	// Quantum length; first intervals skipped as the prescaler may just have changed
	task automatic tick(input int p);
		int n;
		repeat (3) begin
			n = 0;
			do begin
				@(negedge pclk);
				n++;
			end while (quantum_tick !== 1'b1 && n < 300);
		end
		check(n, 2 * (p + 1));
	endtask : tick

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Watchdog well beyond the few thousand cycles the tests need
	initial begin
		#400000;
		miscompares++;
		$display("unexpected at %0t: watchdog expired", $time);
		finish_test();
	end

	initial begin
		seed = 32'h71A6B2C2;
		m = '{32'h0, 32'h0, 32'h0, CTRL_RESET};
		{presetn, psel, penable, pwrite, paddr, pwdata, events} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++)
			rd(2'(i));
		$display("reset test done");
		wr(IDX_TIMING, 32'h0002_2B45);
		repeat (12) begin
			v = $random(seed) & TIMING_WMASK;
			if (!v[PH2PROG_BIT])
				v[18:16] = v[13:11];
			wr(IDX_TIMING, v);
		end
		wr(IDX_CTRL, 32'h0080_8000);
		for (int p = 0; p < 64; p += 63) begin
			wr(IDX_TIMING, 32'h0002_2B40 | 32'(p));
			tick(p);
		end
		$display("timing test done");
		// Leaving configuration: timing write refused, refusal raises irq
		wr(IDX_CTRL, 32'h0);
		apb(1'b1, APB_MASK, 32'h2, r);
		apb(1'b1, APB_WDATA, 32'h0002_2B45, r);
		apb(1'b1, APB_CMD, 32'h3, r);
		@(negedge pclk);
		check(irq, 1'b1);
		apb(1'b0, APB_STATUS, 32'h0, r);
		check(r[ST_REFUSED], 1'b1);
		@(negedge pclk);
		check(irq, 1'b0);
		rd(IDX_TIMING);
		apb(1'b0, 8'h14, 32'h0, r);
		check(r, 32'h0);
		$display("mode test done");
		wr(IDX_INTR, 32'hFFFF_FFFF);
		wr(IDX_INTR, 32'h0);
		repeat (8) begin
			pulse(9'($random(seed)));
			rd(IDX_INTR);
			wr(IDX_INTR, $random(seed));
		end
		pulse(9'h020);
		wr(IDX_INTR, 32'h0);
		wr(IDX_CTRL, 32'h0080_8000);
		wr(IDX_CTRL, 32'h0080_0000);
		rd(IDX_INTR);
		$display("interrupt test done");
		wr(IDX_FILTER, 32'hEA55);
		wr(IDX_FILTER, 32'h8055);
		wr(IDX_FILTER, 32'h6A55);
		repeat (12)
			wr(IDX_FILTER, $random(seed) & 32'hFFFF);
		$display("filter test done");
		finish_test();
	end
endmodule : can_timing_irq_filter_cfg_test
